// >>> logic/fnps_map.svh
// Purpose: offsets, field layout and reset values of the frame number block
// Assumes: byte offsets on the controller's register access port
// Notes:   constants only
`ifndef FNPS_MAP_SVH
`define FNPS_MAP_SVH

`define FNPS_ADDR_W          8
`define FNPS_OFS_FRAME_COUNT 8'h3C
`define FNPS_OFS_PERIODIC    8'h40
`define FNPS_FIELD_W         14
`define FNPS_COUNT_W         16
`define FNPS_FIELD_MSB       13
`define FNPS_FRAME_COUNT_RST 16'h0000
`define FNPS_PERIODIC_RST    14'h0000
`define FNPS_FI_NOMINAL      14'h2EDF
`define FNPS_REMAIN_RST      14'h0000

`endif

// >>> logic/fnps_pkg.sv
// Purpose: types shared by the frame number block
// Assumes: nothing beyond the map header
// Notes:   one-hot frame start sequence states
package fnps_pkg;

  typedef enum logic [3:0]
  {
    FNPS_IDLE = 4'h1,
    FNPS_SOF  = 4'h2,
    FNPS_HCCA = 4'h4,
    FNPS_FLAG = 4'h8
  } fnps_state_t;

endpackage : fnps_pkg

// >>> logic/fnps_down_counter.sv
// Purpose: frame remaining down counter with reload
// Assumes: tick is a one-cycle pulse per bit time, same clock
// Notes:   reload pulse marks the frame boundary
`timescale 1ns/1ns
`default_nettype none

module fnps_down_counter
#(
  parameter int WIDTH = 14
)
(
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  input  wire logic             tick,
  input  wire logic             force_load,
  input  wire logic [WIDTH-1:0] load_value,
  output logic      [WIDTH-1:0] count,
  output logic                  reload
);

  logic [WIDTH-1:0] next_count;

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    reload     = force_load | (tick & (count == '0));
    next_count = count;
    if (reload)
    begin
      next_count = load_value;
    end
    else if (tick)
    begin
      next_count = count - WIDTH'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      count <= '0;
    end
    else
    begin
      count <= next_count;
    end
  end

endmodule : fnps_down_counter

`default_nettype wire

// >>> logic/fnps_frame_number.sv
// Purpose: frame count, start-of-frame sequence and periodic start threshold
// Assumes: all inputs come from logic on ref_clk; bit_tick pulses per bit time
// Notes:   registers reached through the controller's register access port
//
// What this block does
// - frame count adds one whenever frame remaining reloads from interval, except in a cycle that writes the count register
// - frame count wraps to zero after FFFFh; register shows bits 13..0
// - entering operational state increments frame count straight away
// - increment, send SOF, write count to HCCA, then allow first ED fetch
// - after HCCA write completes, set start-of-frame flag (status bit 2)
// - hardware reset clears the 14-bit periodic start threshold
// - at threshold, periodic lists take priority over control and bulk
// - a running control or bulk transaction finishes before interrupt list
// - frame remaining counts down per bit time, reloads after reaching zero
// - frame interval defaults to 11,999 bit times after reset
`timescale 1ns/1ns
`default_nettype none
`include "fnps_map.svh"

module fnps_frame_number
(
  input  wire logic                          ref_clk,
  input  wire logic                          rstn,
  input  wire logic                          bit_tick,
  input  wire logic                          operational_state,
  input  wire logic                          fi_wr,
  input  wire logic [`FNPS_FIELD_W-1:0]      fi_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  input  wire logic [`FNPS_ADDR_W-1:0]       reg_addr,
  input  wire logic [31:0]                   reg_wdata,
  output logic      [31:0]                   reg_rdata,
  output logic                               reg_rvalid,
  input  wire logic                          hcca_wr_ack,
  output logic                               hcca_wr_req,
  output logic      [`FNPS_COUNT_W-1:0]      hcca_wr_data,
  output logic                               sof_send,
  output logic                               start_of_frame_flag,
  output logic                               ed_fetch_allow,
  output logic      [`FNPS_FIELD_W-1:0]      remaining_bit_times,
  input  wire logic                          xfer_busy,
  output logic                               periodic_priority,
  output logic                               nonperiodic_allow,
  output logic                               periodic_start,
  output fnps_pkg::fnps_state_t              seq_state
);
  import fnps_pkg::*;

  logic [`FNPS_FIELD_W-1:0] frame_interval_value;
  logic [`FNPS_FIELD_W-1:0] next_frame_interval_value;
  logic [`FNPS_COUNT_W-1:0] frame_count_field;
  logic [`FNPS_COUNT_W-1:0] next_frame_count_field;
  logic [`FNPS_FIELD_W-1:0] periodic_start_reg;
  logic [`FNPS_FIELD_W-1:0] next_periodic_start_reg;
  logic                     op_prev;
  logic                     op_enter;
  logic                     boundary;
  logic                     pend;
  logic                     next_pend;
  fnps_state_t              next_seq_state;
  logic [`FNPS_COUNT_W-1:0] next_hcca_wr_data;
  logic [31:0]              next_reg_rdata;
  logic                     wr_count;
  logic                     wr_periodic;

  ////////////////////////////////////////////////////////////////////////
  // frame remaining counter and its reload
  assign op_enter = operational_state & ~op_prev;

  fnps_down_counter
  #(
    .WIDTH (`FNPS_FIELD_W)
  )
  u_remaining
  (
    .ref_clk    (ref_clk),
    .rstn       (rstn),
    .tick       (bit_tick),
    .force_load (op_enter),
    .load_value (frame_interval_value),
    .count      (remaining_bit_times),
    .reload     (boundary)
  );

  ////////////////////////////////////////////////////////////////////////
  // registers
  assign wr_count    = reg_wr & (reg_addr == `FNPS_OFS_FRAME_COUNT);
  assign wr_periodic = reg_wr & (reg_addr == `FNPS_OFS_PERIODIC);

  always_comb
  begin
    next_frame_interval_value = frame_interval_value;
    if (fi_wr)
    begin
      next_frame_interval_value = fi_wdata;
    end
    next_periodic_start_reg = periodic_start_reg;
    if (wr_periodic)
    begin
      // reserved bits are not stored, so they always read back zero
      next_periodic_start_reg = reg_wdata[`FNPS_FIELD_MSB:0];
    end
    next_frame_count_field = frame_count_field;
    if (wr_count)
    begin
      next_frame_count_field = {2'h0, reg_wdata[`FNPS_FIELD_MSB:0]};
    end
    else if (boundary)
    begin
      // 16-bit add wraps to zero after FFFFh by itself
      next_frame_count_field = frame_count_field + 16'h0001;
    end
    next_reg_rdata = 32'h0000_0000;
    if (reg_rd)
    begin
      unique case (reg_addr)
        `FNPS_OFS_FRAME_COUNT:
          next_reg_rdata = {18'h00000, frame_count_field[`FNPS_FIELD_MSB:0]};
        `FNPS_OFS_PERIODIC:
          next_reg_rdata = {18'h00000, periodic_start_reg};
        default:
          next_reg_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      frame_interval_value <= `FNPS_FI_NOMINAL;
      periodic_start_reg   <= `FNPS_PERIODIC_RST;
      frame_count_field    <= `FNPS_FRAME_COUNT_RST;
      op_prev              <= 1'b0;
      reg_rdata            <= 32'h0000_0000;
      reg_rvalid           <= 1'b0;
    end
    else
    begin
      frame_interval_value <= next_frame_interval_value;
      periodic_start_reg   <= next_periodic_start_reg;
      frame_count_field    <= next_frame_count_field;
      op_prev              <= operational_state;
      reg_rdata            <= next_reg_rdata;
      reg_rvalid           <= reg_rd;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // frame start sequence: SOF, count to HCCA, flag, then ED fetch
  always_comb
  begin
    next_seq_state    = seq_state;
    next_hcca_wr_data = hcca_wr_data;
    unique case (seq_state)
      FNPS_IDLE:
      begin
        if (boundary)
        begin
          next_seq_state = FNPS_SOF;
        end
      end
      FNPS_SOF:
      begin
        // the count already holds the new frame's value here
        next_hcca_wr_data = frame_count_field;
        next_seq_state    = FNPS_HCCA;
      end
      FNPS_HCCA:
      begin
        if (hcca_wr_ack)
        begin
          next_seq_state = FNPS_FLAG;
        end
      end
      FNPS_FLAG:
      begin
        next_seq_state = FNPS_IDLE;
      end
      default:
      begin
        next_seq_state = FNPS_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      seq_state    <= FNPS_IDLE;
      hcca_wr_data <= `FNPS_FRAME_COUNT_RST;
    end
    else
    begin
      seq_state    <= next_seq_state;
      hcca_wr_data <= next_hcca_wr_data;
    end
  end

  assign sof_send            = (seq_state == FNPS_SOF);
  assign hcca_wr_req         = (seq_state == FNPS_HCCA);
  assign start_of_frame_flag = (seq_state == FNPS_FLAG);
  // ED fetch waits until the count is in memory and the flag is raised
  assign ed_fetch_allow      = (seq_state == FNPS_IDLE) & ~boundary;

  ////////////////////////////////////////////////////////////////////////
  // periodic start threshold
  always_comb
  begin
    next_pend = pend;
    if (boundary)
    begin
      next_pend = 1'b0;
    end
    else if (remaining_bit_times == periodic_start_reg)
    begin
      next_pend = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pend <= 1'b0;
    end
    else
    begin
      pend <= next_pend;
    end
  end

  assign periodic_priority = pend;
  // no new control or bulk work once the threshold is met
  assign nonperiodic_allow = ~pend;
  // running transaction is never cut short; list waits for it
  assign periodic_start    = pend & ~xfer_busy;

endmodule : fnps_frame_number

`default_nettype wire

// >>> verif/fnps_chk_asserts.sv
// Purpose: port checks for the frame number block
// Assumes: one clock, reset async and active low
// Notes:   bound onto the top module
`timescale 1ns/1ns
`default_nettype none

module fnps_chk
(
  input wire logic                  ref_clk,
  input wire logic                  rstn,
  input wire logic                  bit_tick,
  input wire logic                  operational_state,
  input wire logic                  reg_rvalid,
  input wire logic [31:0]           reg_rdata,
  input wire logic                  hcca_wr_ack,
  input wire logic                  hcca_wr_req,
  input wire logic                  sof_send,
  input wire logic                  start_of_frame_flag,
  input wire logic                  ed_fetch_allow,
  input wire logic [13:0]           remaining_bit_times,
  input wire logic                  xfer_busy,
  input wire logic                  periodic_priority,
  input wire logic                  nonperiodic_allow,
  input wire logic                  periodic_start,
  input wire fnps_pkg::fnps_state_t seq_state
);
  import fnps_pkg::*;

  logic bnd;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  assign bnd = bit_tick && remaining_bit_times == 14'h0000;

  a_tick_decr: assert property (bit_tick && !bnd
    && !$rose(operational_state) |=> remaining_bit_times
    == $past(remaining_bit_times) - 14'h0001) else $error("no decrement");
  a_idle_hold: assert property (!bit_tick
    && !$rose(operational_state) |=> $stable(remaining_bit_times))
    else $error("remaining moved");
  a_sof_start: assert property ((bnd || $rose(operational_state))
    && seq_state == FNPS_IDLE |=> sof_send && !ed_fetch_allow)
    else $error("no sof");
  a_sof_hcca: assert property (sof_send |=> hcca_wr_req
    && seq_state == FNPS_HCCA) else $error("no hcca write");
  a_ed_blocked: assert property (hcca_wr_req |-> !ed_fetch_allow)
    else $error("ed fetch early");
  a_flag_ack: assert property (seq_state == FNPS_HCCA
    && hcca_wr_ack |=> start_of_frame_flag && !hcca_wr_req)
    else $error("no flag");
  a_flag_cause: assert property (start_of_frame_flag |->
    $past(seq_state) == FNPS_HCCA && $past(hcca_wr_ack))
    else $error("stray flag");
  a_prio_clear: assert property (bnd
    || $rose(operational_state) |=> !periodic_priority)
    else $error("priority kept");
  a_prio_hold: assert property (periodic_priority && !bnd
    && !$rose(operational_state) |=> periodic_priority)
    else $error("priority lost");
  a_nonper_gate: assert property (nonperiodic_allow
    != periodic_priority) else $error("bad nonperiodic");
  a_start_gate: assert property (periodic_start
    == (periodic_priority && !xfer_busy)) else $error("bad start");
  a_read_upper: assert property (reg_rvalid |->
    reg_rdata[31:14] == 18'h00000) else $error("upper bits set");
endmodule : fnps_chk

bind fnps_frame_number fnps_chk chk_u (.*);

`default_nettype wire

// >>> verif/fnps_frame_number_tb.sv
// Purpose: self-checking bench for the frame number block
// Assumes: 20 MHz ref_clk, inputs driven on the falling edge
// Notes:   short frame interval keeps frames at 17 to 32 cycles
`timescale 1ns/1ns
`default_nettype none

module fnps_frame_number_tb;
  import fnps_pkg::*;

  logic        ref_clk = 0, rstn = 0, bit_tick = 0;
  logic        operational_state = 0, fi_wr = 0, reg_wr = 0;
  logic        reg_rd = 0, hcca_wr_ack = 0, xfer_busy = 0;
  logic        reg_rvalid, hcca_wr_req, sof_send, start_of_frame_flag;
  logic        ed_fetch_allow, periodic_priority, nonperiodic_allow;
  logic        periodic_start, chk_on = 0, req_d = 0, hit = 0;
  logic [13:0] fi_wdata = 0, remaining_bit_times, ps = 0;
  logic [7:0]  reg_addr = 0;
  logic [31:0] reg_wdata = 0, reg_rdata;
  logic [15:0] hcca_wr_data, exp_cnt = 0;
  logic [16:0] rnd = 17'h129C9;
  fnps_state_t seq_state;
  int          num_errors = 0, check_count = 0;

  fnps_frame_number dut_u (.*);

  always #25 ref_clk = ~ref_clk;

  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction : lfsr

  function automatic logic [31:0] exp_field(input logic [15:0] c);
    return {18'h0, c[13:0]};
  endfunction : exp_field

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    check_count++;
    if (seen !== want)
    begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge ref_clk);
    reg_wr = 0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] want);
    reg_rd = 1;
    reg_addr = a;
    @(negedge ref_clk);
    // read data stands for one cycle only, so take it here
    check({31'h0, reg_rvalid}, 32'h1);
    check(reg_rdata, want);
    reg_rd = 0;
    @(negedge ref_clk);
  endtask : rd

  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////////////////////
  // memory side acks at random; busy toggles so both start gates are seen
  always @(negedge ref_clk)
  begin
    rnd <= lfsr(rnd);
    xfer_busy <= rnd[0];
    hcca_wr_ack <= hcca_wr_req & (rnd[1] | rnd[2]);
    req_d <= hcca_wr_req;
    hit <= chk_on && remaining_bit_times == ps;
    if (chk_on && hcca_wr_req && !req_d)
    begin
      check({16'h0, hcca_wr_data}, {16'h0, exp_cnt});
      exp_cnt <= exp_cnt + 16'h0001;
    end
    if (hit)
    begin
      check({31'h0, periodic_priority}, 32'h1);
      check({31'h0, periodic_start}, {31'h0, !xfer_busy});
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5) @(negedge ref_clk);
    rstn = 1;
    @(negedge ref_clk);
    rd(8'h3C, 32'h0);
    rd(8'h40, 32'h0);
    rd(8'h44, 32'h0);
    $display("test reset done");
    // entering operational with no interval write loads the nominal value
    operational_state = 1;
    @(negedge ref_clk);
    check({18'h0, remaining_bit_times}, 32'h2EDF);
    operational_state = 0;
    // let the frame start sequence of that entry finish
    repeat (8) @(negedge ref_clk);
    $display("test interval done");
    fi_wdata = 14'h0010 + {10'h0, rnd[5:2]};
    ps = 14'h0005 + {11'h0, rnd[4:2]};
    fi_wr = 1;
    wr(8'h40, {18'h0, ps});
    fi_wr = 0;
    rd(8'h40, {18'h0, ps});
    exp_cnt = {2'h0, rnd[16:3]};
    wr(8'h3C, {16'h0, exp_cnt});
    rd(8'h3C, {16'h0, exp_cnt});
    exp_cnt = exp_cnt + 16'h0001;
    chk_on = 1;
    // entering operational must bump the count with no reload wait
    operational_state = 1;
    @(negedge ref_clk);
    bit_tick = 1;
    repeat (120) @(negedge ref_clk);
    bit_tick = 0;
    repeat (12) @(negedge ref_clk);
    chk_on = 0;
    rd(8'h3C, exp_field(exp_cnt - 16'h0001));
    $display("test frames done");
    // interval zero makes every tick a boundary, so the wrap is reachable
    fi_wdata = 14'h0000;
    fi_wr = 1;
    operational_state = 0;
    wr(8'h3C, 32'h3FFF);
    fi_wr = 0;
    operational_state = 1;
    repeat (3) @(negedge ref_clk);
    // bit 14 reaches memory, which is what lets software extend the count
    check({16'h0, hcca_wr_data}, 32'h4000);
    bit_tick = 1;
    repeat (32'h0000C001) @(negedge ref_clk);
    bit_tick = 0;
    rd(8'h3C, exp_field(16'h0001));
    $display("test wrap done");
    finish_test;
  end

  initial
  begin
    repeat (32'h00011170) @(posedge ref_clk);
    num_errors++;
    finish_test;
  end
endmodule : fnps_frame_number_tb

`default_nettype wire
